// >>> design/sbw_addr.v
// File address former: access bank or bank select register page.
// Assumes a 12-bit data space with a 4-bit bank number.
`timescale 1ns/1ps
`include "sbw_defs.vh"
module sbw_addr #(
    parameter ACCESS_SPLIT = 8'h80
) (
    // Instruction fields and bank select register value
    input wire [7:0] faddr,
    input wire access_sel,
    input wire [3:0] bank,
    // Full data address
    output wire [11:0] addr
);
    // Low half of access bank maps to bank 0, upper half to bank 15
    wire [3:0] acc_bank;
    assign acc_bank = (faddr < ACCESS_SPLIT) ? 4'h0 : 4'hf;
    assign addr = access_sel ? {bank, faddr} // [RQ8]
                             : {acc_bank, faddr}; // [RQ7]
endmodule // sbw_addr

// >>> design/sbw_alu.v
// Eight-bit subtractor that forms minuend minus W and all status flags.
// Assumes purely combinational use by the sequencer.
`timescale 1ns/1ps
`include "sbw_defs.vh"
module sbw_alu (
    // Operands
    input wire [7:0] minuend,
    input wire [7:0] wreg,
    // Result
    output wire [7:0] diff,
    output wire [4:0] flags
);
    wire [8:0] full;
    wire [4:0] low;
    // Two's complement: add inverted W plus one, carry out is no-borrow
    assign full = {1'b0, minuend} + {1'b0, ~wreg} + 9'h001; // [RQ1] [RQ4]
    assign low = {1'b0, minuend[3:0]} + {1'b0, ~wreg[3:0]} + 5'h01;
    assign diff = full[7:0]; // [RQ13]
    assign flags[`SBW_FLG_C] = full[8]; // [RQ10] [RQ11] [RQ12]
    assign flags[`SBW_FLG_DC] = low[4]; // [RQ14]
    assign flags[`SBW_FLG_Z] = (full[7:0] == 8'h00); // [RQ11]
    assign flags[`SBW_FLG_OV] = (minuend[7] != wreg[7]) &&
        (full[7] != minuend[7]); // [RQ14]
    assign flags[`SBW_FLG_N] = full[7]; // [RQ12]
endmodule // sbw_alu

// >>> design/sbw_core.v
// Behaviour
// (RQ1) Literal subtract computes literal minus W
// (RQ2) Literal subtract always writes W
// (RQ3) Literal subtract: four phases, W written Q4
// (RQ4) File subtract computes file minus W
// (RQ5) Destination bit 0 writes W only
// (RQ6) Destination bit 1 writes file register
// (RQ7) Access bit 0 uses access bank
// (RQ8) Access bit 1 uses bank select register
// (RQ9) File subtract: read Q2, write Q4
// (RQ10) Positive result: carry set, zero clear
// (RQ11) Zero result: carry and zero set
// (RQ12) Borrow clears carry, negative from MSB
// (RQ13) Differences wrap modulo 256
// (RQ14) Overflow and digit carry also updated
//
// Subtract-W execution block with Q1..Q4 sequencer and AXI4-Lite regs.
// Assumes file memory answers reads combinationally in the same cycle.
`timescale 1ns/1ps
`include "sbw_defs.vh"
module sbw_core (
    // Clock, reset, enable
    input wire clk,
    input wire rst_b,
    input wire ce,
    // AXI4-Lite write address
    input wire [3:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    // AXI4-Lite write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    // AXI4-Lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // AXI4-Lite read address
    input wire [3:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    // AXI4-Lite read data
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // File register memory
    output reg [11:0] file_addr,
    input wire [7:0] file_rdata,
    output reg [7:0] file_wdata,
    output reg file_we
);
    localparam ST_IDLE = 2'h0;
    localparam ST_RUN = 2'h1;
    localparam ST_DONE = 2'h2;

    // Sequencer and architectural state
    reg [1:0] state;
    reg [1:0] phase;
    reg [15:0] insn;
    reg [7:0] wreg;
    reg [4:0] status;
    reg [3:0] bank;
    reg [7:0] operand;
    reg [7:0] result;
    reg [4:0] res_flags;
    reg bad_op;
    reg start;
    reg [1:0] next_state;

    // Latched write address/data, taken in either order
    reg aw_held;
    reg w_held;
    reg [3:0] aw_addr;
    reg [31:0] w_data;
    reg [3:0] w_strb;

    wire [7:0] alu_diff;
    wire [4:0] alu_flags;
    wire [11:0] eff_addr;
    wire is_lit;
    wire is_file;
    wire dest_f;
    wire wr_fire;
    wire busy;
    wire wreg_wr;

    // A byte lane keeps its old value while its strobe is low
    function [7:0] lane_merge;
        input [7:0] old;
        input [7:0] data;
        input strb;
        begin
            lane_merge = strb ? data : old;
        end
    endfunction

    // Opcode decode; any other word is flagged illegal and writes nothing
    assign is_lit = (insn[15:8] == `SBW_OPC_LIT); // [RQ1]
    assign is_file = (insn[15:10] == `SBW_OPC_FILE); // [RQ4]
    assign dest_f = insn[9];

    // Subtractor is purely combinational; operands come from flops
    sbw_alu u_alu (
        .minuend(operand),
        .wreg(wreg),
        .diff(alu_diff),
        .flags(alu_flags)
    );

    // Page is chosen in Q1 and latched into file_addr
    sbw_addr u_addr (
        .faddr(insn[7:0]),
        .access_sel(insn[8]),
        .bank(bank),
        .addr(eff_addr)
    );

    always @* begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (start) begin
                    next_state = ST_RUN;
                end
            end
            ST_RUN: begin
                if (phase == `SBW_PHASES) begin
                    next_state = ST_DONE;
                end
            end
            // Spare cycle lets the file write land before busy drops
            ST_DONE: begin
                next_state = ST_IDLE;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // Busy flag: instruction and W writes are refused while an instruction runs; bank writes are still taken
    // Start counts as busy, so a status poll in that cycle is not fooled
    assign busy = (state != ST_IDLE) || start;
    // W write from the bus, taken only between instructions
    assign wreg_wr = wr_fire && (aw_addr == `SBW_ADDR_WREG) && !busy;

    // Q1 decode, Q2 read, Q3 process, Q4 write; one phase per clock
    always @(posedge clk) begin
        if (!rst_b) begin
            state <= ST_IDLE;
            phase <= 2'h0;
            operand <= 8'h00;
            result <= 8'h00;
            res_flags <= 5'h00;
            wreg <= `SBW_RST_WREG;
            status <= 5'h00;
            bad_op <= 1'b0;
            file_addr <= 12'h000;
            file_wdata <= 8'h00;
            file_we <= 1'b0;
        end else if (ce) begin
            state <= next_state;
            file_we <= 1'b0;
            if (state == ST_RUN) begin
                phase <= phase + 2'h1;
                case (phase)
                    2'h0: begin
                        bad_op <= !(is_lit || is_file);
                        // Latched, so a later bank write cannot move it
                        file_addr <= eff_addr; // [RQ7] [RQ8]
                    end
                    2'h1: begin
                        // Literal or file operand read in Q2
                        operand <= is_lit ? insn[7:0] // [RQ3]
                                          : file_rdata; // [RQ9]
                    end
                    2'h2: begin
                        result <= alu_diff; // [RQ13]
                        res_flags <= alu_flags; // [RQ10] [RQ14]
                    end
                    default: begin
                        // Illegal opcode: status and W keep their values
                        if (!bad_op) begin
                            status <= res_flags; // [RQ11] [RQ12]
                            if (is_file && dest_f) begin
                                file_wdata <= result; // [RQ6] [RQ9]
                                file_we <= 1'b1;
                            end else begin
                                wreg <= result; // [RQ2] [RQ3] [RQ5]
                            end
                        end
                    end
                endcase
            end else begin
                phase <= 2'h0;
                if (wreg_wr) begin
                    wreg <= lane_merge(wreg, w_data[7:0], w_strb[0]);
                end
            end
        end
    end

    // AXI4-Lite write side
    // A pending response stalls both channels: one write at a time
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    assign wr_fire = aw_held && w_held && !s_axi_bvalid;

    always @(posedge clk) begin
        if (!rst_b) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 4'h0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `SBW_RESP_OKAY;
            insn <= 16'h0000;
            bank <= `SBW_RST_BANK;
            start <= 1'b0;
        end else if (ce) begin
            start <= 1'b0;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= `SBW_RESP_OKAY;
                case (aw_addr)
                    `SBW_ADDR_CTRL: begin
                        bank <= w_strb[0] ? w_data[3:0] : bank;
                    end
                    `SBW_ADDR_INSN: begin
                        // Writing an instruction launches it
                        if (busy) begin
                            s_axi_bresp <= `SBW_RESP_SLVERR;
                        end else begin
                            insn[7:0] <= lane_merge(insn[7:0],
                                w_data[7:0], w_strb[0]);
                            insn[15:8] <= lane_merge(insn[15:8],
                                w_data[15:8], w_strb[1]);
                            start <= 1'b1;
                        end
                    end
                    `SBW_ADDR_WREG: begin
                        if (busy) begin
                            s_axi_bresp <= `SBW_RESP_SLVERR;
                        end
                    end
                    default: begin
                        s_axi_bresp <= `SBW_RESP_SLVERR;
                    end
                endcase
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // AXI4-Lite read side
    // Registered answer one edge after ar; unmapped reads return zero
    assign s_axi_arready = !s_axi_rvalid;

    always @(posedge clk) begin
        if (!rst_b) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `SBW_RESP_OKAY;
        end else if (ce) begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= `SBW_RESP_OKAY;
                case (s_axi_araddr)
                    `SBW_ADDR_CTRL: s_axi_rdata <= {28'h000_0000, bank};
                    `SBW_ADDR_INSN: s_axi_rdata <= {16'h0000, insn};
                    `SBW_ADDR_WREG: s_axi_rdata <= {24'h00_0000, wreg};
                    `SBW_ADDR_STAT: begin
                        s_axi_rdata <= {16'h0000, 6'h00, busy, bad_op,
                            3'h0, status};
                    end
                    default: begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= `SBW_RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule // sbw_core

// >>> pkg/sbw_defs.vh
// Constants for the subtract-W execution block: opcodes, flag positions,
// register offsets, reset values and phase timing.
// Assumes inclusion by bare name from design files.
`ifndef SBW_DEFS_VH
`define SBW_DEFS_VH
`define SBW_OPC_LIT 8'h08
`define SBW_OPC_FILE 6'h17
`define SBW_FLG_C 0
`define SBW_FLG_DC 1
`define SBW_FLG_Z 2
`define SBW_FLG_OV 3
`define SBW_FLG_N 4
`define SBW_ADDR_CTRL 4'h0
`define SBW_ADDR_INSN 4'h4
`define SBW_ADDR_WREG 4'h8
`define SBW_ADDR_STAT 4'hc
`define SBW_RST_WREG 8'h00
`define SBW_RST_BANK 4'h0
`define SBW_PHASES 2'h3
`define SBW_RESP_OKAY 2'b00
`define SBW_RESP_SLVERR 2'b10
`endif

// >>> testbench/sbw_core_tb.sv
// Bench for sbw_core: instructions launched and checked over the bus.
// Assumes sbw_mem as file memory; the checker is bound separately.
`timescale 1ns/1ps
`include "sbw_defs.vh"
module sbw_core_tb;
    reg clk = 0, rst_b = 0, ce = 1;
    reg [3:0] awaddr = 0, araddr = 0;
    reg [31:0] wdata = 0, rdv, c;
    reg [3:0] wstrb = 4'hf;
    reg awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    wire awready, wready, bvalid, arready, rvalid, file_we;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire [11:0] file_addr;
    wire [7:0] file_rdata, file_wdata;
    reg [1:0] bre, rrs;
    reg [12:0] e;
    reg [11:0] ea;
    integer num_errors = 0, total_checks = 0, cycles = 0, i;
    // Packed tables, entry 0 in the low bits: {W, literal} and
    // {d, a, bank, file address, file value, W}
    reg [95:0] lit = {16'hff7f, 16'h0120, 16'h0180, 16'h0302, 16'h0202,
        16'h0102};
    reg [127:0] fil = {32'h1a30_5031, 32'h3520_0102, 32'h0590_0202,
        32'h2510_0302};
    always #2 clk = ~clk;
    sbw_core i_sbw_core (.clk(clk), .rst_b(rst_b), .ce(ce),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .file_addr(file_addr),
        .file_rdata(file_rdata), .file_wdata(file_wdata), .file_we(file_we));
    sbw_mem i_sbw_mem (.clk(clk), .file_addr(file_addr),
        .file_rdata(file_rdata), .file_wdata(file_wdata), .file_we(file_we));
    task end_of_test;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // Generous ceiling; a full run needs well under a thousand cycles
    always @(posedge clk) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            num_errors = num_errors + 1;
            end_of_test;
        end
    end
    task chk(input [39:0] got, input [39:0] exp);
        total_checks = total_checks + 1;
        if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task wr(input [3:0] a, input [31:0] d);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        bre = bresp;
    endtask
    task rd(input [3:0] a);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rready <= 1'b0;
        rdv = rdata;
        rrs = rresp;
    endtask
    task run(input [15:0] insn);
        wr(`SBW_ADDR_INSN, {16'h0000, insn});
        do rd(`SBW_ADDR_STAT); while (rdv[9] !== 1'b0);
    endtask
    // Reference: {N, OV, Z, DC, C, difference}
    function [12:0] ref_sub(input [7:0] m, input [7:0] w);
        reg [7:0] d;
        begin
            d = m - w;
            ref_sub = {d[7], m[7] != w[7] && d[7] != m[7], d == 8'h00,
                m[3:0] >= w[3:0], m >= w, d};
        end
    endfunction
    initial begin
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        rd(`SBW_ADDR_WREG);
        chk(rdv, `SBW_RST_WREG);
        rd(`SBW_ADDR_STAT);
        chk(rdv, 32'h0000_0000);
        $display("reset test done");
        for (i = 0; i < 6; i = i + 1) begin
            wr(`SBW_ADDR_WREG, lit[i*16+8 +: 8]);
            run({`SBW_OPC_LIT, lit[i*16 +: 8]});
            e = ref_sub(lit[i*16 +: 8], lit[i*16+8 +: 8]);
            rd(`SBW_ADDR_WREG);
            chk(rdv, e[7:0]);
            rd(`SBW_ADDR_STAT);
            chk(rdv[4:0], e[12:8]);
        end
        $display("literal test done");
        for (i = 0; i < 4; i = i + 1) begin
            c = fil[i*32 +: 32];
            ea = c[28] ? {c[27:24], c[23:16]} : {{4{c[23]}}, c[23:16]};
            i_sbw_mem.mem[{c[27:24], c[23:16]}] = ~c[15:8];
            i_sbw_mem.mem[{4'h0, c[23:16]}] = ~c[15:8];
            i_sbw_mem.mem[{4'hf, c[23:16]}] = ~c[15:8];
            i_sbw_mem.mem[ea] = c[15:8];
            wr(`SBW_ADDR_CTRL, c[27:24]);
            wr(`SBW_ADDR_WREG, c[7:0]);
            run({`SBW_OPC_FILE, c[29], c[28], c[23:16]});
            e = ref_sub(c[15:8], c[7:0]);
            chk(i_sbw_mem.mem[ea], c[29] ? e[7:0] : c[15:8]);
            rd(`SBW_ADDR_WREG);
            chk(rdv, c[29] ? c[7:0] : e[7:0]);
            rd(`SBW_ADDR_STAT);
            chk(rdv[4:0], e[12:8]);
        end
        $display("file test done");
        rd(4'h2);
        chk({rrs, rdv}, {`SBW_RESP_SLVERR, 32'h0000_0000});
        wr(`SBW_ADDR_STAT, 32'h0000_0000);
        chk(bre, `SBW_RESP_SLVERR);
        wr(`SBW_ADDR_WREG, 32'h0000_0001);
        // No strobe: the write is answered but W keeps its value
        wstrb <= 4'h0;
        wr(`SBW_ADDR_WREG, 32'h0000_0055);
        chk(bre, `SBW_RESP_OKAY);
        wstrb <= 4'hf;
        wr(`SBW_ADDR_INSN, {16'h0000, `SBW_OPC_LIT, 8'h05});
        // Clock enable low freezes the running instruction
        ce <= 1'b0;
        repeat (3) @(posedge clk);
        ce <= 1'b1;
        // Busy: the W write must be refused and change nothing
        wr(`SBW_ADDR_WREG, 32'h0000_0077);
        chk(bre, `SBW_RESP_SLVERR);
        run(16'hffff);
        chk(rdv[8], 1'b1);
        e = ref_sub(8'h05, 8'h01);
        chk(rdv[4:0], e[12:8]);
        rd(`SBW_ADDR_WREG);
        chk(rdv, 32'h0000_0004);
        $display("refusal test done");
        end_of_test;
    end
endmodule // sbw_core_tb

// >>> testbench/sbw_mem.sv
// File register memory model seen by the subtract block.
// Assumes the core holds file_addr while file_we pulses.
`timescale 1ns/1ps
module sbw_mem (
    // Clock
    input wire clk,
    // Access
    input wire [11:0] file_addr,
    output wire [7:0] file_rdata,
    input wire [7:0] file_wdata,
    input wire file_we
);
    reg [7:0] mem [0:4095];
    // Combinational read: the core samples the operand in Q2
    assign file_rdata = mem[file_addr];
    always @(posedge clk) begin
        if (file_we) begin
            mem[file_addr] <= file_wdata;
        end
    end
endmodule // sbw_mem

// >>> testbench/sbw_sva.sv
// Port checker for sbw_core: bus handshakes, refusals, file write pulse.
// Assumes it is bound onto sbw_core and sees only that module's ports.
`timescale 1ns/1ps
`include "sbw_defs.vh"
module sbw_sva (
    // Clock, reset, enable
    input wire clk,
    input wire rst_b,
    input wire ce,
    // Register bus
    input wire s_axi_awready,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0] s_axi_rresp,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    // File memory
    input wire [11:0] file_addr,
    input wire file_we
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("bvalid dropped");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("rvalid dropped");
    AST_R_ANSWER: assert property (s_axi_arvalid && s_axi_arready && ce
        |-> ##[1:2] s_axi_rvalid) else $error("read not answered");
    AST_AW_BLOCK: assert property (s_axi_bvalid |->
        !s_axi_awready && !s_axi_wready) else $error("write taken early");
    AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken early");
    AST_B_DONE: assert property (s_axi_bvalid && s_axi_bready && ce |=>
        !s_axi_bvalid) else $error("write response not released");
    AST_R_DONE: assert property (s_axi_rvalid && s_axi_rready && ce |=>
        !s_axi_rvalid) else $error("read response not released");
    AST_ERR_DATA: assert property (s_axi_rvalid &&
        s_axi_rresp == `SBW_RESP_SLVERR |-> s_axi_rdata == 32'h0000_0000)
        else $error("refused read carries data");
    AST_WE_PULSE: assert property (file_we |=> !file_we)
        else $error("file write longer than one cycle");
    AST_WE_ADDR: assert property (file_we |->
        file_addr == $past(file_addr, 2)) else $error("address moved");
    AST_RESET: assert property ($rose(rst_b) && $past(ce) |-> !file_we &&
        !s_axi_bvalid && !s_axi_rvalid && file_addr == 12'h000)
        else $error("outputs not cleared by reset");
    // Main scenarios reached
    cover property (file_we);
    cover property (s_axi_bvalid && s_axi_bresp == `SBW_RESP_SLVERR);
    cover property (s_axi_rvalid && s_axi_rresp == `SBW_RESP_SLVERR);
endmodule // sbw_sva
bind sbw_core sbw_sva i_sbw_sva (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .s_axi_awready(s_axi_awready),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .file_addr(file_addr),
    .file_we(file_we)
);
